// ### src/wsc_edge.sv
// Wake line edge capture and pending bits
`timescale 1ns/10ps
module wsc_edge
    import wsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [LINES-1:0] line,
    input wire logic [LINES-1:0] pol,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [7:0] wdata,
    output logic [LINES-1:0] pend,
    output logic [LINES-1:0] set_pulse
);
    logic [LINES-1:0] prev;
    logic armed;
    logic [LINES-1:0] next_pend;

    // Edges are suppressed in the first cycle, while prev is still the reset value
    genvar i;
    generate
        for (i = 0; i < LINES; i++) begin : g_line
            assign set_pulse[i] = armed & (pol[i] ? (line[i] & ~prev[i]) : (~line[i] & prev[i]));
        end
    endgenerate

    // Byte writes replace the value, a captured edge wins over the clear
    assign next_pend[7:0] = (wr_lo ? wdata : pend[7:0]) | set_pulse[7:0];
    assign next_pend[15:8] = (wr_hi ? wdata : pend[15:8]) | set_pulse[15:8];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev <= LINE_RST;
            armed <= 1'b0;
            pend <= LINE_RST;
        end else begin
            prev <= line;
            armed <= 1'b1;
            pend <= next_pend;
        end
    end

    pend_set_a: assert property (@(posedge clk) disable iff (!rst_b)
        (set_pulse != LINE_RST) |=> ((pend & $past(set_pulse)) == $past(set_pulse)))
        else $error("captured edge lost its pending bit");
endmodule

// ### src/wsc_pkg.sv
// Constants and types of the wake-up stop entry control block
package wsc_pkg;
    localparam int LINES = 16;
    localparam int SYNC_W = 18;
    // Stop pin idles high, so its synchroniser resets high
    localparam logic [17:0] SYNC_RST = 18'h20000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] LINE_RST = 16'h0000;
    // Register indexes on the byte-wide register port
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_MASK_LO = 4'h1;
    localparam logic [3:0] ADDR_MASK_HI = 4'h2;
    localparam logic [3:0] ADDR_POL_LO = 4'h3;
    localparam logic [3:0] ADDR_POL_HI = 4'h4;
    localparam logic [3:0] ADDR_PEND_LO = 4'h5;
    localparam logic [3:0] ADDR_PEND_HI = 4'h6;
    localparam logic [3:0] ADDR_TOP = 4'h7;
    localparam logic [3:0] ADDR_CLKF = 4'h8;
    localparam logic [3:0] ADDR_CHAN = 4'h9;
    // Field positions
    localparam int CTRL_WAKE = 0;
    localparam int CTRL_SRC = 1;
    localparam int CTRL_STOP = 2;
    localparam int TOP_EDGE = 3;
    localparam int TOP_GIE = 4;
    localparam int TOP_MASK = 5;
    localparam int TOP_PEND = 6;
    localparam int TOP_NMS = 7;
    localparam int CLKF_EXIT = 7;
    localparam int CHAN_MASK = 6;
    localparam int CHAN_PEND = 7;
    // Oscillator restart time, a least time, rounded up
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_RESTART_NS = 1000;
    localparam int OSC_RESTART_CYC = (OSC_RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    typedef enum logic [2:0] {SEQ_IDLE, SEQ_ONE, SEQ_ZERO, SEQ_STOPPED, SEQ_WAKING} wsc_state_type;
    typedef struct packed {
        logic stop;
        logic src_en;
        logic wake_mode;
    } wsc_ctrl_type;
    typedef struct packed {
        logic nms;
        logic pend;
        logic mask;
        logic gie;
        logic edge_sel;
    } wsc_top_type;
    // Write decode for one register index
    function automatic logic wsc_hit(input logic wr, input logic [3:0] a, input logic [3:0] r);
        return wr && (a == r);
    endfunction
endpackage

// ### src/wsc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module wsc_sync
    import wsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [SYNC_W-1:0] din,
    output logic [SYNC_W-1:0] dout
);
    logic [SYNC_W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= SYNC_RST;
            dout <= SYNC_RST;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// ### src/wsc_top.sv
// Wake-up line unit: stop entry sequence, wake exit, top-level and channel requests
//
// Summary of operation
// - Stop bit writes 1,0,1 with pin low enter stop
// - Wake line exit clears stop bit, flag set
// - Pin rising exit keeps stop bit, flag set
// - Malformed sequence with pin high leaves both clear
// - Pin high at third write refuses, bit stays
// - Later pin fall after refusal never enters stop
// - Pin rise during sequence aborts, both read zero
// - Unmasked line event during sequence aborts, pending set
// - Exit flag sticky; cleared when entry is filtered
// - Any unmasked wake line ends stop after restart
// - Pin rising edge wakes like a seventeenth line
// - Pending bits edge captured, an edge in the clear's cycle wins
// - Edge select set: pin rise sets top pending
// - Top request if nonmaskable, or mask and enable
// - Steady high pin: no handler, no stop entry
// - Pin dropped before third write allows stop entry
// - Channel pending set on rise of unmasked pendings
// - Entry needs wake mode, no unmasked pending, one mask
// - Channel needs source enable, wake needs mode
// - Polarity bit selects falling or rising edge
// - Low stop pin forces stop regardless of bit
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
module wsc_top
    import wsc_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic [LINES-1:0] WAKE_LINE,
    input wire logic NMI_PIN,
    input wire logic STOP_PIN_B,
    input wire logic INT_ACK,
    output logic STOP_REQ,
    output logic TOP_INT_REQ,
    output logic WAKE_INT_REQ
);
    localparam int WAKE_MIN = OSC_RESTART_CYC;
    localparam int WAKE_MAX = OSC_RESTART_CYC + 2;
    localparam logic [CNT_W-1:0] RESTART_LOAD = CNT_W'(OSC_RESTART_CYC - 1);

    wsc_state_type state;
    wsc_state_type next_state;
    wsc_ctrl_type ctrl;
    wsc_ctrl_type next_ctrl;
    wsc_top_type top;
    wsc_top_type next_top;
    logic [SYNC_W-1:0] pins_s;
    logic [LINES-1:0] line_s;
    logic nmi_s;
    logic stop_pin_s;
    logic nmi_d;
    logic armed;
    logic nmi_rise;
    logic [LINES-1:0] mask;
    logic [LINES-1:0] pol;
    logic [LINES-1:0] pend;
    logic [LINES-1:0] set_pulse;
    logic exit_flag;
    logic next_exit;
    logic chan_pend;
    logic chan_mask;
    logic wake_ch_d;
    logic clr_d;
    logic in_stop;
    logic [CNT_W-1:0] wake_cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [7:0] rd_mux;

    // Pin synchronisation; nothing reads the raw pins
    wsc_sync u_sync (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .din({STOP_PIN_B, NMI_PIN, WAKE_LINE}),
        .dout(pins_s)
    );

    assign line_s = pins_s[LINES-1:0];
    assign nmi_s = pins_s[LINES];
    assign stop_pin_s = pins_s[LINES+1];

    // Register write decode
    wire wr_ctrl = wsc_hit(REG_WR, REG_ADDR, ADDR_CTRL);
    wire wr_mask_lo = wsc_hit(REG_WR, REG_ADDR, ADDR_MASK_LO);
    wire wr_mask_hi = wsc_hit(REG_WR, REG_ADDR, ADDR_MASK_HI);
    wire wr_pol_lo = wsc_hit(REG_WR, REG_ADDR, ADDR_POL_LO);
    wire wr_pol_hi = wsc_hit(REG_WR, REG_ADDR, ADDR_POL_HI);
    wire wr_pend_lo = wsc_hit(REG_WR, REG_ADDR, ADDR_PEND_LO);
    wire wr_pend_hi = wsc_hit(REG_WR, REG_ADDR, ADDR_PEND_HI);
    wire wr_top = wsc_hit(REG_WR, REG_ADDR, ADDR_TOP);
    wire wr_clkf = wsc_hit(REG_WR, REG_ADDR, ADDR_CLKF);
    wire wr_chan = wsc_hit(REG_WR, REG_ADDR, ADDR_CHAN);
    wire stop_val = REG_WDATA[CTRL_STOP];

    // Edge capture and pending bits of the sixteen lines
    wsc_edge u_edge (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .line(line_s),
        .pol(pol),
        .wr_lo(wr_pend_lo),
        .wr_hi(wr_pend_hi),
        .wdata(REG_WDATA),
        .pend(pend),
        .set_pulse(set_pulse)
    );

    // Pin edge; armed masks the reset value of the delay stage
    assign nmi_rise = armed & nmi_s & ~nmi_d;

    // Line aggregation
    wire [LINES-1:0] unmasked = pend & mask;
    wire any_unmasked = |unmasked;
    wire any_mask = |mask;
    wire new_unmasked = |(set_pulse & mask);
    wire wake_ch = ctrl.src_en & any_unmasked;
    wire wake_ev = ctrl.wake_mode & any_unmasked;
    // A clear that leaves another unmasked bit set gives the channel a fresh edge
    wire [LINES-1:0] pend_keep = {wr_pend_hi ? REG_WDATA : ~BYTE_RST, wr_pend_lo ? REG_WDATA : ~BYTE_RST};
    wire clr_unmasked = |(unmasked & ~pend_keep);
    wire chan_rise = wake_ch & (~wake_ch_d | clr_d);

    // Any write to a register other than the control register breaks the sequence; acks always break it too
    wire other_write = REG_WR & ~wr_ctrl;
    wire abort = other_write | INT_ACK | nmi_rise | new_unmasked;
    wire in_seq = (state == SEQ_ONE) || (state == SEQ_ZERO);
    wire third_ok = (state == SEQ_ZERO) && wr_ctrl && stop_val && !abort;
    wire entry_ok = ~nmi_s & ctrl.wake_mode & ~any_unmasked & any_mask;

    // Stop sequence and stop state
    always_comb begin
        next_state = state;
        next_ctrl = ctrl;
        next_cnt = wake_cnt;
        next_exit = wr_clkf ? REG_WDATA[CLKF_EXIT] : exit_flag;
        if (wr_ctrl) begin
            next_ctrl.wake_mode = REG_WDATA[CTRL_WAKE];
            next_ctrl.src_en = REG_WDATA[CTRL_SRC];
        end
        unique case (state)
            SEQ_IDLE: begin
                if (wr_ctrl) begin
                    next_ctrl.stop = stop_val;
                    if (stop_val) begin
                        next_state = SEQ_ONE;
                    end
                end
            end
            SEQ_ONE: begin
                if (abort) begin
                    next_state = SEQ_IDLE;
                    next_ctrl.stop = 1'b0;
                    next_exit = 1'b0;
                end else if (wr_ctrl) begin
                    next_ctrl.stop = stop_val;
                    next_state = stop_val ? SEQ_ONE : SEQ_ZERO;
                end
            end
            SEQ_ZERO: begin
                if (abort) begin
                    next_state = SEQ_IDLE;
                    next_ctrl.stop = 1'b0;
                    next_exit = 1'b0;
                end else if (wr_ctrl) begin
                    next_state = SEQ_IDLE;
                    if (!stop_val) begin
                        next_ctrl.stop = 1'b0;
                        next_exit = 1'b0;
                    end else if (nmi_s) begin
                        next_ctrl.stop = 1'b1;
                        next_exit = 1'b0;
                    end else if (entry_ok) begin
                        next_ctrl.stop = 1'b1;
                        next_state = SEQ_STOPPED;
                    end else begin
                        next_ctrl.stop = 1'b0;
                        next_exit = 1'b0;
                    end
                end
            end
            SEQ_STOPPED: begin
                // The pin acts as an extra wake source whatever the edge select
                if (nmi_rise) begin
                    next_state = SEQ_WAKING;
                    next_cnt = RESTART_LOAD;
                end else if (wake_ev) begin
                    next_state = SEQ_WAKING;
                    next_ctrl.stop = 1'b0;
                    next_cnt = RESTART_LOAD;
                end
            end
            SEQ_WAKING: begin
                // Clock held off until the oscillator has restarted
                if (wake_cnt == CNT_ZERO) begin
                    next_state = SEQ_IDLE;
                end else begin
                    next_cnt = wake_cnt - CNT_ONE;
                end
            end
        endcase
        // Genuine exit sets the flag; the set wins over a clear
        if (state == SEQ_STOPPED && next_state == SEQ_WAKING) begin
            next_exit = 1'b1;
        end
    end

    // Top-level pin interrupt; nonmaskable select only reset clears
    always_comb begin
        next_top = top;
        if (wr_top) begin
            next_top.edge_sel = REG_WDATA[TOP_EDGE];
            next_top.gie = REG_WDATA[TOP_GIE];
            next_top.mask = REG_WDATA[TOP_MASK];
            next_top.pend = REG_WDATA[TOP_PEND];
            next_top.nms = top.nms | REG_WDATA[TOP_NMS];
        end
        if (nmi_rise && top.edge_sel) begin
            next_top.pend = 1'b1;
        end
    end

    // State, control and restart counter
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            state <= SEQ_IDLE;
            ctrl <= '0;
            top <= '0;
            wake_cnt <= CNT_ZERO;
            exit_flag <= 1'b0;
            in_stop <= 1'b0;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
            top <= next_top;
            wake_cnt <= next_cnt;
            exit_flag <= next_exit;
            in_stop <= (next_state == SEQ_STOPPED) || (next_state == SEQ_WAKING);
        end
    end

    // Mask and polarity bytes
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            mask <= LINE_RST;
            pol <= LINE_RST;
        end else begin
            if (wr_mask_lo) mask[7:0] <= REG_WDATA;
            if (wr_mask_hi) mask[15:8] <= REG_WDATA;
            if (wr_pol_lo) pol[7:0] <= REG_WDATA;
            if (wr_pol_hi) pol[15:8] <= REG_WDATA;
        end
    end

    // Channel pending; a rise of the combined request wins over a clear
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            chan_pend <= 1'b0;
            chan_mask <= 1'b0;
            wake_ch_d <= 1'b0;
            clr_d <= 1'b0;
        end else begin
            chan_pend <= (wr_chan ? REG_WDATA[CHAN_PEND] : chan_pend) | chan_rise;
            if (wr_chan) chan_mask <= REG_WDATA[CHAN_MASK];
            wake_ch_d <= wake_ch;
            clr_d <= clr_unmasked;
        end
    end

    // Pin delay stage for the rising edge
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            nmi_d <= 1'b0;
            armed <= 1'b0;
        end else begin
            nmi_d <= nmi_s;
            armed <= 1'b1;
        end
    end

    // Read selection; unmapped indexes read zero
    assign rd_mux = (REG_ADDR == ADDR_CTRL) ? {5'h00, ctrl.stop, ctrl.src_en, ctrl.wake_mode} :
        (REG_ADDR == ADDR_MASK_LO) ? mask[7:0] :
        (REG_ADDR == ADDR_MASK_HI) ? mask[15:8] :
        (REG_ADDR == ADDR_POL_LO) ? pol[7:0] :
        (REG_ADDR == ADDR_POL_HI) ? pol[15:8] :
        (REG_ADDR == ADDR_PEND_LO) ? pend[7:0] :
        (REG_ADDR == ADDR_PEND_HI) ? pend[15:8] :
        (REG_ADDR == ADDR_TOP) ? {top.nms, top.pend, top.mask, top.gie, top.edge_sel, 3'h0} :
        (REG_ADDR == ADDR_CLKF) ? {exit_flag, 7'h00} :
        (REG_ADDR == ADDR_CHAN) ? {chan_pend, chan_mask, 6'h00} : BYTE_RST;

    // Read data stand for one cycle only
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= BYTE_RST;
        end else begin
            REG_RDATA <= REG_RD ? rd_mux : BYTE_RST;
        end
    end

    // External stop pin bypasses the sequence entirely
    assign STOP_REQ = in_stop | ~stop_pin_s;
    assign TOP_INT_REQ = top.pend & (top.nms | (top.mask & top.gie));
    assign WAKE_INT_REQ = chan_pend & chan_mask;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_B);

    stop_entry_a: assert property (
        third_ok && entry_ok |=> (state == SEQ_STOPPED) && ctrl.stop && STOP_REQ)
        else $error("correct sequence did not enter stop");

    line_exit_a: assert property (
        (state == SEQ_STOPPED) && !nmi_rise && wake_ev |=> !ctrl.stop && exit_flag && in_stop)
        else $error("line wake left wrong stop bit or flag");

    pin_exit_a: assert property (
        (state == SEQ_STOPPED) && nmi_rise |=> ctrl.stop && exit_flag)
        else $error("pin wake left wrong stop bit or flag");

    restart_time_a: assert property (
        (state == SEQ_STOPPED) && (nmi_rise || wake_ev) |=> in_stop ##[WAKE_MIN:WAKE_MAX] !in_stop)
        else $error("clock did not resume after restart delay");

    pin_refuse_a: assert property (
        third_ok && nmi_s |=> ctrl.stop && !exit_flag && !in_stop)
        else $error("high pin at third write not refused");

    seq_abort_a: assert property (
        in_seq && abort |=> !ctrl.stop && !exit_flag && (state == SEQ_IDLE))
        else $error("aborted sequence left stop bit or flag");

    no_entry_a: assert property (
        third_ok && !nmi_s && !entry_ok |=> !ctrl.stop && !in_stop)
        else $error("stop entered without its conditions");

    idle_stay_a: assert property (
        (state == SEQ_IDLE) |=> !in_stop || !stop_pin_s && STOP_REQ)
        else $error("stop entered outside a sequence");

    top_pend_a: assert property (
        nmi_rise && top.edge_sel |=> top.pend && TOP_INT_REQ == (top.nms || top.mask && top.gie))
        else $error("pin rise did not set top pending");

    nms_sticky_a: assert property (
        top.nms |=> top.nms)
        else $error("nonmaskable select cleared without reset");

    chan_rise_a: assert property (
        $rose(wake_ch) |=> chan_pend)
        else $error("channel rise lost");

    stop_pin_a: assert property (
        !stop_pin_s |-> STOP_REQ)
        else $error("stop pin ignored");

    entry_c: cover property (third_ok && entry_ok ##1 (state == SEQ_STOPPED));
    pin_wake_c: cover property ((state == SEQ_STOPPED) && nmi_rise);
    line_wake_c: cover property ((state == SEQ_STOPPED) && wake_ev && !nmi_rise);
    refuse_c: cover property (third_ok && nmi_s);
endmodule

// ### tb/tb.sv
// Self-checking bench of the wake-up stop entry control block
`timescale 1ns/10ps
module tb
    import wsc_pkg::*;
;
    typedef struct packed {
        logic [3:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } wsc_row_type;

    logic clk, rst_b, wr, rd, nmi, stop_b, ack_go, int_ack, stop_req, top_req, wake_req;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, rv;
    logic [LINES-1:0] wline;
    int err_total, comparisons, n;
    // Register rows: written value and value read back; the unmapped index reads zero
    wsc_row_type rows [9] = '{'{ADDR_MASK_HI, 8'hA5, 8'hA5}, '{ADDR_POL_HI, 8'h5A, 8'h5A},
        '{ADDR_POL_LO, 8'h3C, 8'h3C}, '{ADDR_MASK_LO, 8'h01, 8'h01}, '{ADDR_POL_LO, 8'h01, 8'h01},
        '{ADDR_MASK_HI, 8'h00, 8'h00}, '{ADDR_POL_HI, 8'h00, 8'h00}, '{4'hF, 8'hFF, 8'h00},
        '{ADDR_CTRL, 8'h03, 8'h03}};

    wsc_top dut (.CLK_SYS(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .WAKE_LINE(wline), .NMI_PIN(nmi), .STOP_PIN_B(stop_b),
        .INT_ACK(int_ack), .STOP_REQ(stop_req), .TOP_INT_REQ(top_req), .WAKE_INT_REQ(wake_req));
    wsc_cpu_model u_cpu (.clk(clk), .rst_b(rst_b), .top_req(top_req), .ack_go(ack_go), .int_ack(int_ack));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One write cycle; the leading edge keeps the strobe from being set twice in one step
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        rv = rdata;
        chk(rv, e);
    endtask

    // Settle past the edge so flags are read after their updates land
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic bit_chk(input logic b, input logic e);
        chk({7'h00, b}, {7'h00, e});
    endtask

    // Stop request must hold for at least the oscillator restart count
    task automatic wait_wake;
        n = 0;
        while (stop_req === 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        bit_chk(n >= OSC_RESTART_CYC && n < 400, 1'b1);
    endtask

    // A pin refusal or pin wake leaves a stored stop bit behind; a foreign write ends any sequence first
    task automatic tidy;
        wreg(ADDR_CLKF, 8'h00);
        wreg(ADDR_CTRL, 8'h03);
    endtask

    task automatic close_out;
        $display("Mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        rst_b = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00; wline = LINE_RST;
        nmi = 1'b0; stop_b = 1'b1; ack_go = 1'b0; err_total = 0; comparisons = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        cyc(2);
        bit_chk(stop_req, 1'b0);
        for (int i = 0; i < 10; i++) rchk(4'(i), 8'h00);
        foreach (rows[i]) begin
            wreg(rows[i].a, rows[i].d);
            rchk(rows[i].a, rows[i].e);
        end
        // External stop pin forces a request whatever the stop bit
        stop_b <= 1'b0;
        cyc(4);
        bit_chk(stop_req, 1'b1);
        stop_b <= 1'b1;
        cyc(4);
        bit_chk(stop_req, 1'b0);
        // Line 1 has falling polarity
        wline[1] <= 1'b1;
        cyc(4);
        rchk(ADDR_PEND_LO, 8'h00);
        wline[1] <= 1'b0;
        cyc(4);
        rchk(ADDR_PEND_LO, 8'h02);
        wreg(ADDR_PEND_LO, 8'h01);
        wreg(ADDR_CTRL, 8'h07);
        wreg(ADDR_CTRL, 8'h03);
        wreg(ADDR_CTRL, 8'h07);
        cyc(3);
        bit_chk(stop_req, 1'b0);
        rchk(ADDR_CTRL, 8'h03);
        wreg(ADDR_PEND_LO, 8'h00);
        // Correct sequence, then a wake line ends stop
        wreg(ADDR_CTRL, 8'h07);
        wreg(ADDR_CTRL, 8'h03);
        wreg(ADDR_CTRL, 8'h07);
        cyc(2);
        bit_chk(stop_req, 1'b1);
        rchk(ADDR_CTRL, 8'h07);
        wline[0] <= 1'b1;
        wait_wake();
        rchk(ADDR_CTRL, 8'h03);
        rchk(ADDR_CLKF, 8'h80);
        wreg(ADDR_PEND_LO, 8'h00);
        rchk(ADDR_PEND_LO, 8'h00);
        wreg(ADDR_CLKF, 8'h00);
        wline[0] <= 1'b0;
        // Pin dropped before the third write, then a pin rise wakes
        nmi <= 1'b1;
        cyc(4);
        wreg(ADDR_CTRL, 8'h07);
        wreg(ADDR_CTRL, 8'h03);
        nmi <= 1'b0;
        cyc(4);
        wreg(ADDR_CTRL, 8'h07);
        cyc(2);
        bit_chk(stop_req, 1'b1);
        nmi <= 1'b1;
        wait_wake();
        rchk(ADDR_CTRL, 8'h07);
        rchk(ADDR_CLKF, 8'h80);
        tidy();
        // Pin steady high: malformed, then correct sequence
        wreg(ADDR_CTRL, 8'h07);
        wreg(ADDR_CTRL, 8'h03);
        wreg(ADDR_CTRL, 8'h03);
        rchk(ADDR_CTRL, 8'h03);
        rchk(ADDR_CLKF, 8'h00);
        wreg(ADDR_CTRL, 8'h07);
        wreg(ADDR_CTRL, 8'h03);
        wreg(ADDR_CTRL, 8'h07);
        cyc(3);
        bit_chk(stop_req, 1'b0);
        rchk(ADDR_CTRL, 8'h07);
        rchk(ADDR_CLKF, 8'h00);
        nmi <= 1'b0;
        cyc(10);
        bit_chk(stop_req, 1'b0);
        tidy();
        // Pin rise in mid-sequence
        wreg(ADDR_CTRL, 8'h07);
        wreg(ADDR_CTRL, 8'h03);
        nmi <= 1'b1;
        cyc(4);
        rchk(ADDR_CTRL, 8'h03);
        rchk(ADDR_CLKF, 8'h00);
        wreg(ADDR_CTRL, 8'h07);
        cyc(2);
        bit_chk(stop_req, 1'b0);
        nmi <= 1'b0;
        tidy();
        // Wake line event in mid-sequence
        wreg(ADDR_CTRL, 8'h07);
        wreg(ADDR_CTRL, 8'h03);
        wline[0] <= 1'b1;
        cyc(4);
        rchk(ADDR_CTRL, 8'h03);
        rchk(ADDR_PEND_LO, 8'h01);
        wreg(ADDR_CTRL, 8'h07);
        cyc(2);
        bit_chk(stop_req, 1'b0);
        wreg(ADDR_PEND_LO, 8'h00);
        wline[0] <= 1'b0;
        tidy();
        // Commanded acknowledge in mid-sequence
        wreg(ADDR_CTRL, 8'h07);
        ack_go <= 1'b1;
        @(posedge clk);
        ack_go <= 1'b0;
        wreg(ADDR_CTRL, 8'h03);
        wreg(ADDR_CTRL, 8'h07);
        cyc(2);
        bit_chk(stop_req, 1'b0);
        rchk(ADDR_CLKF, 8'h00);
        tidy();
        // Channel edges from unmasked pendings
        wreg(ADDR_MASK_LO, 8'h03);
        wreg(ADDR_CHAN, 8'h40);
        wreg(ADDR_PEND_LO, 8'h03);
        cyc(3);
        bit_chk(wake_req, 1'b1);
        wreg(ADDR_CHAN, 8'h40);
        cyc(2);
        bit_chk(wake_req, 1'b0);
        wreg(ADDR_PEND_LO, 8'h02);
        cyc(3);
        bit_chk(wake_req, 1'b1);
        wreg(ADDR_CHAN, 8'h00);
        wreg(ADDR_PEND_HI, 8'h00);
        wreg(ADDR_CHAN, 8'h00);
        wreg(ADDR_PEND_LO, 8'h00);
        wreg(ADDR_CHAN, 8'h40);
        cyc(3);
        bit_chk(wake_req, 1'b0);
        rchk(ADDR_CHAN, 8'h40);
        wreg(ADDR_MASK_LO, 8'h01);
        // Top-level pending and request; the non-maskable select goes last as it is sticky
        wreg(ADDR_TOP, 8'h18);
        nmi <= 1'b1;
        cyc(4);
        bit_chk(top_req, 1'b0);
        rchk(ADDR_TOP, 8'h58);
        wreg(ADDR_TOP, 8'h78);
        cyc(1);
        bit_chk(top_req, 1'b1);
        wreg(ADDR_TOP, 8'h98);
        cyc(8);
        bit_chk(top_req, 1'b0);
        nmi <= 1'b0;
        cyc(4);
        nmi <= 1'b1;
        cyc(4);
        bit_chk(top_req, 1'b1);
        wreg(ADDR_TOP, 8'h00);
        rchk(ADDR_TOP, 8'h80);
        // Only a reset clears the sticky non-maskable select
        nmi <= 1'b0;
        cyc(4);
        rst_b <= 1'b0;
        cyc(2);
        rst_b <= 1'b1;
        cyc(2);
        bit_chk(stop_req, 1'b0);
        rchk(ADDR_TOP, 8'h00);
        close_out();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule

// ### tb/wsc_cpu_model.sv
// CPU interrupt acknowledge model facing the wake-up unit
`timescale 1ns/10ps
module wsc_cpu_model
    import wsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic top_req,
    input wire logic ack_go,
    output logic int_ack
);
    logic top_seen;

    // A fresh top request or a commanded acknowledge (ack_go) earns a one-cycle acknowledge;
    // the acknowledge is what filters a stop sequence, so it is never withheld
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            top_seen <= 1'b0;
            int_ack <= 1'b0;
        end else begin
            top_seen <= top_req;
            int_ack <= (top_req && !top_seen) || ack_go;
        end
    end
endmodule
